// ---- core/seq_branch_pulse.sv ----
// Conditional branch opcodes and encoder pulse accumulator of the sequence interpreter.
`timescale 1ns/1ps

// Functional notes
// R01: Every conditional branch takes its target sequence number from the low byte of the command value.
// R02: Opcode 40 jumps to the target when the last compare found the parameter greater than the value.
// R03: Opcode 41 jumps to the target when the last compare result was zero.
// R04: Opcode 42 jumps to the target when the last compare found the parameter greater or equal.
// R05: Opcode 43 jumps to the target when the last compare found the parameter less or equal.
// R06: A branch whose condition fails advances the sequence counter by one.
// R07: Opcode 44 clears the pulse accumulator to zero.
// R08: Opcode 45 compares the accumulator with the register picked by the low byte and sets the condition code.
// R09: Opcode 46 with low byte 1 makes each pulse decrement the accumulator.
// R10: Opcode 46 with low byte 0 makes each pulse increment the accumulator.
// R11: A compare subtracts the command value from the stored value and leaves the stored value alone; the code subtracts the register picked by the low byte.
// R12: The command value splits into a high and a low byte, the low byte picking operand or target.
// R13: The condition code holds sign and zero of the latest compare until the next compare.
// R14: Each qualified pulse is counted once on the clock, in the direction the flag selects; the code drops a pulse that comes in the same cycle as opcode 44.
module seq_branch_pulse #(
  parameter int SEQ_W = 8,
  parameter int ACC_W = 16,
  parameter int NREG = 16
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Command issue from the sequence engine.
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_op_i,
  input wire logic [15:0] cmd_value_i,
  input wire logic [SEQ_W-1:0] seq_i,
  // Compare register file, flattened.
  input wire logic [NREG*ACC_W-1:0] regs_i,
  // Encoder pulse, one cycle per qualified pulse.
  input wire logic pulse_i,
  // Results.
  output logic seq_load_o,
  output logic [SEQ_W-1:0] seq_next_o,
  output logic [ACC_W-1:0] acc_o,
  output logic dir_down_o,
  output logic cc_sign_o,
  output logic cc_zero_o
);
  // R12: command value split.
  wire logic [7:0] low_byte = cmd_value_i[seq_branch_pkg::LOW_BYTE_LSB +: 8];
  wire logic [7:0] high_byte = cmd_value_i[seq_branch_pkg::HIGH_BYTE_LSB +: 8];

  wire logic is_gt = cmd_valid_i && cmd_op_i == seq_branch_pkg::OP_BR_GT;
  wire logic is_eq = cmd_valid_i && cmd_op_i == seq_branch_pkg::OP_BR_EQ;
  wire logic is_ge = cmd_valid_i && cmd_op_i == seq_branch_pkg::OP_BR_GE;
  wire logic is_le = cmd_valid_i && cmd_op_i == seq_branch_pkg::OP_BR_LE;
  wire logic is_clr = cmd_valid_i && cmd_op_i == seq_branch_pkg::OP_ACC_CLR;
  wire logic is_cmp = cmd_valid_i && cmd_op_i == seq_branch_pkg::OP_ACC_CMP;
  wire logic is_dir = cmd_valid_i && cmd_op_i == seq_branch_pkg::OP_ACC_DIR;
  wire logic is_branch = is_gt || is_eq || is_ge || is_le;

  logic [ACC_W-1:0] acc_reg;
  logic dir_reg;
  logic sign_reg;
  logic zero_reg;
  logic seq_load_reg;
  logic [SEQ_W-1:0] seq_next_reg;

  // R02: greater means result positive and non-zero.
  wire logic take_gt = is_gt && !sign_reg && !zero_reg;
  // R03: equal means zero result.
  wire logic take_eq = is_eq && zero_reg;
  // R04: greater or equal means non-negative.
  wire logic take_ge = is_ge && !sign_reg;
  // R05: less or equal means negative or zero.
  wire logic take_le = is_le && (sign_reg || zero_reg);
  wire logic take = take_gt || take_eq || take_ge || take_le;

  // R01: target from low byte; R06: otherwise step by one.
  wire logic [SEQ_W-1:0] target = SEQ_W'(low_byte);
  wire logic [SEQ_W-1:0] seq_plus = seq_i + SEQ_W'(1);
  wire logic [SEQ_W-1:0] seq_next_next = take ? target : seq_plus;

  // R08: operand register picked by the low byte; out-of-range picks zero.
  wire logic sel_ok = 32'(low_byte) < NREG;
  wire logic [ACC_W-1:0] sel_reg = sel_ok ? regs_i[32'(low_byte)*ACC_W +: ACC_W] : '0;
  // R11: subtract the register value from the accumulator, keeping both unchanged.
  wire logic [ACC_W:0] diff = {1'b0, acc_reg} - {1'b0, sel_reg};
  wire logic sign_next = diff[ACC_W];
  wire logic zero_next = diff[ACC_W-1:0] == '0;

  // R09: low byte 1 selects down; R10: low byte 0 selects up.
  wire logic dir_set = is_dir && (low_byte == seq_branch_pkg::DIR_DOWN_CODE
    || low_byte == seq_branch_pkg::DIR_UP_CODE);
  wire logic dir_next = dir_set ? (low_byte == seq_branch_pkg::DIR_DOWN_CODE) : dir_reg;

  // R07: clear wins over a pulse in the same cycle; R09: down; R10: up.
  // R14: one count per clocked pulse.
  wire logic [ACC_W-1:0] acc_next = is_clr ? '0 :
    !pulse_i ? acc_reg :
    dir_reg ? acc_reg - ACC_W'(1) : acc_reg + ACC_W'(1);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_reg <= '0;
      dir_reg <= seq_branch_pkg::RST_DIR;
      sign_reg <= seq_branch_pkg::RST_SIGN;
      zero_reg <= seq_branch_pkg::RST_ZERO;
      seq_load_reg <= 1'b0;
      seq_next_reg <= '0;
    end else begin
      acc_reg <= acc_next;
      dir_reg <= dir_next;
      seq_load_reg <= is_branch;
      if (is_branch) begin
        seq_next_reg <= seq_next_next;
      end
      // R08: condition code updated only by the compare; R13: held otherwise.
      if (is_cmp) begin
        sign_reg <= sign_next;
        zero_reg <= zero_next;
      end
    end
  end

  assign seq_load_o = seq_load_reg;
  assign seq_next_o = seq_next_reg;
  assign acc_o = acc_reg;
  assign dir_down_o = dir_reg;
  assign cc_sign_o = sign_reg;
  assign cc_zero_o = zero_reg;

  wire logic unused_high = ^high_byte;

  a_branch_target: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R01
    take |=> seq_load_o && seq_next_o == $past(target)) else $error("Taken branch lost its target.");
  a_gt_branch: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R02
    is_gt && !cc_sign_o && !cc_zero_o |=> seq_next_o == $past(target)) else $error("Greater branch not taken.");
  a_eq_branch: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R03
    is_eq && cc_zero_o |=> seq_next_o == $past(target)) else $error("Equal branch not taken.");
  a_ge_branch: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R04
    is_ge && !cc_sign_o |=> seq_next_o == $past(target)) else $error("Greater-equal branch not taken.");
  a_le_branch: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R05
    is_le && (cc_sign_o || cc_zero_o) |=> seq_next_o == $past(target)) else $error("Less-equal branch not taken.");
  a_fall_through: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R06
    is_branch && !take |=> seq_load_o && seq_next_o == $past(seq_i) + SEQ_W'(1))
    else $error("Failed branch did not step by one.");
  a_acc_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R07
    is_clr |=> acc_o == '0) else $error("Accumulator not cleared.");
  a_cmp_sets_cc: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R08
    is_cmp |=> cc_zero_o == ($past(acc_o) == $past(sel_reg))) else $error("Compare zero flag wrong.");
  a_dir_down: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R09
    is_dir && low_byte == 8'h01 ##1 pulse_i && !is_clr |=> acc_o == $past(acc_o) - ACC_W'(1))
    else $error("Down count wrong.");
  a_dir_up: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R10
    is_dir && low_byte == 8'h00 ##1 pulse_i && !is_clr |=> acc_o == $past(acc_o) + ACC_W'(1))
    else $error("Up count wrong.");
  a_cc_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R13
    !is_cmp |=> $stable(cc_sign_o) && $stable(cc_zero_o)) else $error("Condition code moved without compare.");
  a_high_byte_free: assert property (@(posedge clk_i) disable iff (!rst_n_i) // R12
    take |=> seq_next_o[7:0] == $past(cmd_value_i[7:0])) else $error("Target not from low byte.");
endmodule // seq_branch_pulse

// ---- core/seq_branch_pkg.sv ----
// Constants shared by the sequence branch and pulse counter block.
package seq_branch_pkg;
  localparam logic [7:0] OP_BR_GT = 8'h28;
  localparam logic [7:0] OP_BR_EQ = 8'h29;
  localparam logic [7:0] OP_BR_GE = 8'h2A;
  localparam logic [7:0] OP_BR_LE = 8'h2B;
  localparam logic [7:0] OP_ACC_CLR = 8'h2C;
  localparam logic [7:0] OP_ACC_CMP = 8'h2D;
  localparam logic [7:0] OP_ACC_DIR = 8'h2E;
  localparam int LOW_BYTE_LSB = 0;
  localparam int HIGH_BYTE_LSB = 8;
  localparam logic [7:0] DIR_DOWN_CODE = 8'h01;
  localparam logic [7:0] DIR_UP_CODE = 8'h00;
  localparam logic RST_DIR = 1'b0;
  localparam logic RST_SIGN = 1'b0;
  localparam logic RST_ZERO = 1'b0;
endpackage

// ---- sim/enc_model.sv ----
// Encoder model that sends qualified count pulses at random.
`timescale 1ns/1ps
module enc_model (
  // Clock and enable.
  input wire logic clk_i,
  input wire logic en_i,
  // Pulse to the accumulator.
  output logic pulse_o
);
  initial pulse_o = 1'b0;
  always @(posedge clk_i) begin
    pulse_o <= #1 en_i & 1'($urandom_range(1, 0));
  end
endmodule // enc_model

// ---- sim/tb_top.sv ----
// Self-checking bench for the branch and pulse accumulator block.
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic [7:0] cmd_op_i = 8'h00;
  logic [15:0] cmd_value_i = 16'h0000;
  logic [7:0] seq_i = 8'h00;
  logic [255:0] regs_i = '0;
  logic en = 1'b0;
  logic pulse_i, seq_load_o, dir_down_o, cc_sign_o, cc_zero_o, ld_m, tk;
  logic [7:0] seq_next_o;
  logic [15:0] acc_o;
  logic [15:0] acc_m = 16'h0000;
  logic dir_m = 1'b0, sg_m = 1'b0, zr_m = 1'b0;
  int err_total = 0, samples_checked = 0, cyc = 0;
  always #10 clk_i = ~clk_i;
  seq_branch_pulse seq_branch_pulse_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid_i),
    .cmd_op_i(cmd_op_i), .cmd_value_i(cmd_value_i), .seq_i(seq_i), .regs_i(regs_i), .pulse_i(pulse_i),
    .seq_load_o(seq_load_o), .seq_next_o(seq_next_o), .acc_o(acc_o), .dir_down_o(dir_down_o),
    .cc_sign_o(cc_sign_o), .cc_zero_o(cc_zero_o));
  enc_model enc_model_i (.clk_i(clk_i), .en_i(en), .pulse_o(pulse_i));
  function automatic logic [15:0] sel_reg(input logic [7:0] k);
    return (k < 8'h10) ? regs_i[k*16 +: 16] : 16'h0000;
  endfunction
  function automatic logic taken(input logic [7:0] op);
    case (op)
      seq_branch_pkg::OP_BR_GT: return !sg_m && !zr_m;
      seq_branch_pkg::OP_BR_EQ: return zr_m;
      seq_branch_pkg::OP_BR_GE: return !sg_m;
      default: return sg_m || zr_m;
    endcase
  endfunction
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic step(input logic v, input logic [7:0] op, input logic [15:0] val);
    cmd_valid_i = v;
    cmd_op_i = op;
    cmd_value_i = val;
    seq_i = 8'($urandom);
    @(posedge clk_i);
    ld_m = v && op >= 8'h28 && op <= 8'h2B;
    tk = taken(op);
    if (v && op == seq_branch_pkg::OP_ACC_CMP) begin
      sg_m = acc_m < sel_reg(val[7:0]);
      zr_m = acc_m == sel_reg(val[7:0]);
    end
    if (v && op == seq_branch_pkg::OP_ACC_CLR) acc_m = 16'h0000;
    else if (pulse_i) acc_m = dir_m ? acc_m - 16'h0001 : acc_m + 16'h0001;
    if (v && op == seq_branch_pkg::OP_ACC_DIR && val[7:0] <= 8'h01) dir_m = val[0];
    #1;
    chk(seq_load_o === ld_m, "branch load");
    if (ld_m) chk(seq_next_o === (tk ? val[7:0] : seq_i + 8'h01), "next seq");
    chk(acc_o === acc_m, "accumulator");
    chk({dir_down_o, cc_sign_o, cc_zero_o} === {dir_m, sg_m, zr_m}, "dir or cc");
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    logic [7:0] op, lo;
    void'($urandom(61));
    for (int k = 0; k < 16; k++) regs_i[k*16 +: 16] = 16'($urandom_range(12, 0));
    repeat (2) @(posedge clk_i);
    chk({seq_load_o, acc_o, dir_down_o, cc_sign_o, cc_zero_o} === 20'h00000, "reset state");
    #1 rst_n_i = 1'b1;
    // Out-of-range register compares with zero, then an equal branch follows back to back.
    step(1'b1, seq_branch_pkg::OP_ACC_CMP, 16'hFF11);
    step(1'b1, seq_branch_pkg::OP_BR_EQ, 16'h3C28);
    step(1'b1, seq_branch_pkg::OP_ACC_DIR, 16'h0001);
    en = 1'b1;
    repeat (600) begin
      op = 8'h28 + 8'($urandom_range(7, 0));
      lo = 8'($urandom_range(1, 0) ? $urandom_range(2, 0) : $urandom_range(255, 0));
      step(1'($urandom_range(3, 0) != 0), op, {8'($urandom), lo});
    end
    tally_and_finish();
  end
endmodule // tb_top
